/* File: core/fcp_pwm.sv */
// Four channel PWM controller with prescaler, dividers and Wishbone slave.
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "fcp_params.svh"

module fcp_pwm
  import fcp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              mclk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              periph_clk_en_in,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [ADDR_W-1:0] wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic      [31:0]       wb_dat_out,
  output logic                   wb_ack_out,
  output logic      [3:0]        channel_wave_out,
  output logic                   irq_out
);

  fcp_state_t  st_reg;
  fcp_state_t  st_next;

  logic [`FCP_PRE_TAPS-1:0] pre_tick;
  logic        divided_clock_a_tick;
  logic        divided_clock_b_tick;
  logic [3:0]  ch_tick;
  logic [3:0]  period_end;
  logic        acc;
  logic        wr;
  logic        rd;
  logic [11:0] adr;
  logic        is_ch;
  logic [1:0]  ch_idx;
  logic [4:0]  ch_off;
  logic [31:0] rd_val;
  logic [31:0] mask;
  logic [31:0] wv;
  logic        wr_ctl;

  // Picks one prescaler tap; codes past the last tap give no pulses.
  function automatic logic pick_tap(input logic [`FCP_PRE_TAPS-1:0] t,
                                    input logic [3:0] s);
    logic r;
    r = 1'b0;
    for (int j = 0; j < `FCP_PRE_TAPS; j++) begin
      if (s == 4'(j)) begin
        r = t[j];
      end
    end
    return r;
  endfunction

  // All divided clocks are enables on mclk_in, so no derived clock nets.
  assign pre_tick[0] = periph_clk_en_in;
  genvar k;
  generate
    for (k = 1; k < `FCP_PRE_TAPS; k++) begin : g_tap
      assign pre_tick[k] = periph_clk_en_in & (&st_reg.presc[k-1:0]);
    end
  endgenerate

  assign divided_clock_a_tick = (st_reg.divider_a_factor != 8'h00) &&
                     pick_tap(pre_tick, st_reg.divider_a_source_sel) &&
                     (st_reg.cnta == st_reg.divider_a_factor - 8'h01);
  assign divided_clock_b_tick = (st_reg.divider_b_factor != 8'h00) &&
                     pick_tap(pre_tick, st_reg.divider_b_source_sel) &&
                     (st_reg.cntb == st_reg.divider_b_factor - 8'h01);

  generate
    for (k = 0; k < 4; k++) begin : g_sel
      assign ch_tick[k] =
        (st_reg.ch[k].mode.cpre == `FCP_SEL_DIVIDED_CLOCK_A) ? divided_clock_a_tick :
        (st_reg.ch[k].mode.cpre == `FCP_SEL_DIVIDED_CLOCK_B) ? divided_clock_b_tick :
        pick_tap(pre_tick, st_reg.ch[k].mode.cpre);
    end
  endgenerate

  // Bus decode; the access is taken in the cycle before ack is raised.
  assign acc    = wb_cyc_in & wb_stb_in & ~st_reg.ack;
  assign wr     = acc & wb_we_in;
  assign rd     = acc & ~wb_we_in;
  assign adr    = 12'(wb_adr_in) & 12'hFFC;
  assign is_ch  = (adr[11:7] == `FCP_CH_BASE_HI);
  assign ch_idx = adr[6:5];
  assign ch_off = adr[4:0];
  assign mask   = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                   {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign wv     = (rd_val & ~mask) | (wb_dat_in & mask);
  assign wr_ctl = wr && !is_ch &&
                  (adr == `FCP_OFF_ENA || adr == `FCP_OFF_DIS);

  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_ch) begin
      case (ch_off)
        `FCP_CH_CMR: begin
          rd_val[3:0]            = st_reg.ch[ch_idx].mode.cpre;
          rd_val[`FCP_CMR_CALG]  = st_reg.ch[ch_idx].mode.calg;
          rd_val[`FCP_CMR_CPOL]  = st_reg.ch[ch_idx].mode.cpol;
          rd_val[`FCP_CMR_CPD]   = st_reg.ch[ch_idx].mode.cpd;
        end
        `FCP_CH_DUTY:   rd_val[15:0] = st_reg.ch[ch_idx].duty;
        `FCP_CH_PERIOD: rd_val[15:0] = st_reg.ch[ch_idx].period;
        `FCP_CH_COUNT:  rd_val[15:0] = st_reg.ch[ch_idx].cnt;
        default:        rd_val = 32'h0000_0000;
      endcase
    end else begin
      case (adr)
        `FCP_OFF_MODE: begin
          rd_val[`FCP_MR_DIVIDER_A_FACTOR_LSB +: 8] = st_reg.divider_a_factor;
          rd_val[`FCP_MR_DIVIDER_A_SOURCE_SEL_LSB +: 4] = st_reg.divider_a_source_sel;
          rd_val[`FCP_MR_DIVIDER_B_FACTOR_LSB +: 8] = st_reg.divider_b_factor;
          rd_val[`FCP_MR_DIVIDER_B_SOURCE_SEL_LSB +: 4] = st_reg.divider_b_source_sel;
        end
        `FCP_OFF_STAT: rd_val[3:0] = st_reg.ena;
        `FCP_OFF_IMR:  rd_val[3:0] = st_reg.imr;
        `FCP_OFF_ISR:  rd_val[3:0] = st_reg.isr;
        default:       rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    st_next    = st_reg;
    period_end = 4'h0;

    // The prescaler holds its phase while the peripheral clock is off.
    if (periph_clk_en_in) begin
      st_next.presc = st_reg.presc + 10'h001;
    end
    if (st_reg.divider_a_factor != 8'h00 && pick_tap(pre_tick, st_reg.divider_a_source_sel)) begin
      st_next.cnta = divided_clock_a_tick ? 8'h00 : st_reg.cnta + 8'h01;
    end
    if (st_reg.divider_b_factor != 8'h00 && pick_tap(pre_tick, st_reg.divider_b_source_sel)) begin
      st_next.cntb = divided_clock_b_tick ? 8'h00 : st_reg.cntb + 8'h01;
    end

    for (int i = 0; i < 4; i++) begin
      if (st_reg.ena[i] && ch_tick[i]) begin
        if (st_reg.ch[i].period == 16'h0000) begin
          period_end[i] = 1'b1;
        end else if (!st_reg.ch[i].mode.calg) begin
          if (st_reg.ch[i].cnt >= st_reg.ch[i].period - 16'h0001) begin
            period_end[i] = 1'b1;
          end else begin
            st_next.ch[i].cnt = st_reg.ch[i].cnt + 16'h0001;
          end
        end else if (!st_reg.ch[i].down) begin
          st_next.ch[i].cnt = st_reg.ch[i].cnt + 16'h0001;
          if (st_reg.ch[i].cnt + 16'h0001 >= st_reg.ch[i].period) begin
            st_next.ch[i].down = 1'b1;
          end
        end else if (st_reg.ch[i].cnt <= 16'h0001) begin
          period_end[i] = 1'b1;
        end else begin
          st_next.ch[i].cnt = st_reg.ch[i].cnt - 16'h0001;
        end
        if (period_end[i]) begin
          st_next.ch[i].cnt  = 16'h0000;
          st_next.ch[i].down = 1'b0;
          if (st_reg.ch[i].pend) begin
            st_next.ch[i].pend = 1'b0;
            if (st_reg.ch[i].mode.cpd) begin
              st_next.ch[i].period = st_reg.ch[i].upd;
            end else begin
              st_next.ch[i].duty = st_reg.ch[i].upd;
            end
          end
        end
      end
    end

    // Register writes do not depend on the peripheral clock enable.
    if (wr && is_ch) begin
      case (ch_off)
        `FCP_CH_CMR: begin
          // Mode bits are frozen while the channel runs.
          if (!st_reg.ena[ch_idx]) begin
            st_next.ch[ch_idx].mode.cpre = wv[3:0];
            st_next.ch[ch_idx].mode.calg = wv[`FCP_CMR_CALG];
            st_next.ch[ch_idx].mode.cpol = wv[`FCP_CMR_CPOL];
            st_next.ch[ch_idx].mode.cpd  = wv[`FCP_CMR_CPD];
          end
        end
        `FCP_CH_DUTY: begin
          if (!st_reg.ena[ch_idx]) begin
            st_next.ch[ch_idx].duty = wv[15:0];
          end
        end
        `FCP_CH_PERIOD: begin
          if (!st_reg.ena[ch_idx]) begin
            st_next.ch[ch_idx].period = wv[15:0];
          end
        end
        `FCP_CH_UPDATE: begin
          st_next.ch[ch_idx].upd  = wv[15:0];
          st_next.ch[ch_idx].pend = 1'b1;
        end
        default: begin
        end
      endcase
    end else if (wr) begin
      case (adr)
        `FCP_OFF_MODE: begin
          st_next.divider_a_factor = wv[`FCP_MR_DIVIDER_A_FACTOR_LSB +: 8];
          st_next.divider_a_source_sel = wv[`FCP_MR_DIVIDER_A_SOURCE_SEL_LSB +: 4];
          st_next.divider_b_factor = wv[`FCP_MR_DIVIDER_B_FACTOR_LSB +: 8];
          st_next.divider_b_source_sel = wv[`FCP_MR_DIVIDER_B_SOURCE_SEL_LSB +: 4];
          st_next.cnta = 8'h00;
          st_next.cntb = 8'h00;
        end
        `FCP_OFF_ENA: begin
          // Several bits in one write start those channels together.
          for (int i = 0; i < 4; i++) begin
            if (wv[i] && !st_reg.ena[i]) begin
              st_next.ena[i]     = 1'b1;
              st_next.ch[i].cnt  = 16'h0000;
              st_next.ch[i].down = 1'b0;
            end
          end
        end
        `FCP_OFF_DIS: st_next.ena = st_reg.ena & ~wv[3:0];
        `FCP_OFF_IER: st_next.imr = st_reg.imr | wv[3:0];
        `FCP_OFF_IDR: st_next.imr = st_reg.imr & ~wv[3:0];
        default: begin
        end
      endcase
    end

    // A period end in the same cycle as the status read survives it.
    if (rd && !is_ch && adr == `FCP_OFF_ISR) begin
      st_next.isr = 4'h0;
    end
    st_next.isr = st_next.isr | (period_end & st_reg.ena);

    // The pin is registered, so it trails the counter by one cycle.
    for (int i = 0; i < 4; i++) begin
      if (!st_reg.ena[i]) begin
        st_next.wave[i] = st_reg.ch[i].mode.cpol;
      end else if (st_reg.ch[i].cnt < st_reg.ch[i].duty) begin
        st_next.wave[i] = st_reg.ch[i].mode.cpol;
      end else begin
        st_next.wave[i] = ~st_reg.ch[i].mode.cpol;
      end
    end

    st_next.ack  = acc;
    st_next.rdat = rd ? rd_val : 32'h0000_0000;
    st_next.irq  = |(st_next.isr & st_next.imr);
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_reg <= `FCP_STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_out       = st_reg.rdat;
  assign wb_ack_out       = st_reg.ack;
  assign channel_wave_out = st_reg.wave;
  assign irq_out          = st_reg.irq;

  default clocking ast_cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);

  AST_ACK_FOLLOWS: assert property (
    acc |=> wb_ack_out ##1 !wb_ack_out)
    else $error("Bus request not answered in one cycle.");

  AST_DIV2_SPACING: assert property (
    pre_tick[1] |=> !pre_tick[1] ##1
      (pre_tick[1] || !periph_clk_en_in || !$past(periph_clk_en_in)))
    else $error("Divide-by-two tap not every second cycle.");

  AST_TAPS_STOP: assert property (
    !periph_clk_en_in |-> pre_tick == '0)
    else $error("Prescaler tap pulsed with clock off.");

  AST_ZERO_DIV: assert property (
    st_reg.divider_a_factor == 8'h00 |-> !divided_clock_a_tick)
    else $error("Divider A pulsed with zero divisor.");

  AST_FREEZE: assert property (
    !periph_clk_en_in && !wr |=> $stable(st_reg.ch[0].cnt))
    else $error("Channel counter moved with clock off.");

  AST_ENA_CAUSE: assert property (
    $changed(st_reg.ena) |-> $past(wr_ctl))
    else $error("Enable state changed without a command.");

  AST_END_FLAG: assert property (
    period_end[0] && st_reg.ena[0] |=> st_reg.isr[0])
    else $error("Period end did not set status flag.");

  AST_IRQ_LEVEL: assert property (
    (st_reg.isr & st_reg.imr) != 4'h0 |-> irq_out)
    else $error("Interrupt line low with masked flag set.");

  AST_BUFFER_HOLD: assert property (
    st_reg.ch[0].pend && st_reg.ena[0] && !period_end[0]
      |=> $stable(st_reg.ch[0].period) && $stable(st_reg.ch[0].duty))
    else $error("Buffered value loaded before period end.");

  AST_LEFT_WRAP: assert property (
    st_reg.ena[0] && ch_tick[0] && !st_reg.ch[0].mode.calg &&
    st_reg.ch[0].period != 16'h0000 &&
    st_reg.ch[0].cnt == st_reg.ch[0].period - 16'h0001
      |=> st_reg.ch[0].cnt == 16'h0000 || $past(wr_ctl))
    else $error("Left aligned counter did not wrap.");

  AST_IDLE_LEVEL: assert property (
    !st_reg.ena[1] |=> channel_wave_out[1] == $past(st_reg.ch[1].mode.cpol))
    else $error("Disabled channel output not at polarity.");

  AST_SYNC_START: assert property (
    wr_ctl && adr == `FCP_OFF_ENA && wv[1] && wv[3] &&
    !st_reg.ena[1] && !st_reg.ena[3]
      |=> st_reg.ena[1] && st_reg.ena[3] &&
          st_reg.ch[1].cnt == 16'h0000 && st_reg.ch[3].cnt == 16'h0000)
    else $error("Channels written together did not start together.");

  AST_BUFFER_LOAD: assert property (
    period_end[0] && st_reg.ch[0].pend && !st_reg.ch[0].mode.cpd
      |=> st_reg.ch[0].duty == $past(st_reg.ch[0].upd))
    else $error("Buffered duty not loaded at period end.");

  AST_TICK_ONLY: assert property (
    !ch_tick[2] && !wr |=> $stable(st_reg.ch[2].cnt))
    else $error("Channel counter moved without its clock.");

  AST_CENTER_TURN: assert property (
    st_reg.ena[2] && ch_tick[2] && st_reg.ch[2].mode.calg &&
    st_reg.ch[2].down && st_reg.ch[2].cnt == 16'h0001
      |=> st_reg.ch[2].cnt == 16'h0000 && !st_reg.ch[2].down)
    else $error("Center aligned counter did not end at zero.");

  AST_FROZEN_SEL: assert property (
    st_reg.ch[3].mode.cpre == `FCP_SEL_DIVIDED_CLOCK_B && st_reg.divider_b_factor == 8'h00
      |-> !ch_tick[3])
    else $error("Channel on a stopped divider received a clock.");

endmodule
`default_nettype wire

/* File: core/fcp_params.svh */
// Register offsets, field positions, reset values and codes of the PWM block.
`ifndef FCP_PARAMS_SVH
`define FCP_PARAMS_SVH

`define FCP_OFF_MODE     12'h000
`define FCP_OFF_ENA      12'h004
`define FCP_OFF_DIS      12'h008
`define FCP_OFF_STAT     12'h00C
`define FCP_OFF_IER      12'h010
`define FCP_OFF_IDR      12'h014
`define FCP_OFF_IMR      12'h018
`define FCP_OFF_ISR      12'h01C
`define FCP_CH_BASE_HI   5'h04
`define FCP_CH_CMR       5'h00
`define FCP_CH_DUTY      5'h04
`define FCP_CH_PERIOD    5'h08
`define FCP_CH_COUNT     5'h0C
`define FCP_CH_UPDATE    5'h10

`define FCP_MR_DIVIDER_A_FACTOR_LSB  0
`define FCP_MR_DIVIDER_A_SOURCE_SEL_LSB  8
`define FCP_MR_DIVIDER_B_FACTOR_LSB  16
`define FCP_MR_DIVIDER_B_SOURCE_SEL_LSB  24
`define FCP_CMR_CALG     8
`define FCP_CMR_CPOL     9
`define FCP_CMR_CPD      10

`define FCP_SEL_LAST_PRE 4'hA
`define FCP_SEL_DIVIDED_CLOCK_A     4'hB
`define FCP_SEL_DIVIDED_CLOCK_B     4'hC
`define FCP_PRE_TAPS     11
`define FCP_STATE_RESET  '0

`endif

/* File: core/fcp_pkg.sv */
// Types of the four channel PWM block.
package fcp_pkg;

  typedef struct packed {
    logic [3:0] cpre;
    logic       calg;
    logic       cpol;
    logic       cpd;
  } fcp_cmode_t;

  typedef struct packed {
    fcp_cmode_t  mode;
    logic [15:0] duty;
    logic [15:0] period;
    logic [15:0] upd;
    logic        pend;
    logic [15:0] cnt;
    logic        down;
  } fcp_chan_t;

  typedef struct packed {
    logic [3:0]           divider_a_source_sel;
    logic [7:0]           divider_a_factor;
    logic [3:0]           divider_b_source_sel;
    logic [7:0]           divider_b_factor;
    logic [3:0]           ena;
    logic [3:0]           imr;
    logic [3:0]           isr;
    logic [9:0]           presc;
    logic [7:0]           cnta;
    logic [7:0]           cntb;
    fcp_chan_t [3:0]      ch;
    logic [3:0]           wave;
    logic                 ack;
    logic [31:0]          rdat;
    logic                 irq;
  } fcp_state_t;

endpackage

/* File: verification/fcp_pin_monitor.sv */
// Pin-side model: measures period and high time of one channel output.
`timescale 1ns/1ns
`default_nettype none
module fcp_pin_monitor (
  input  wire logic        mclk_in,
  input  wire logic [3:0]  wave_in,
  input  wire logic [1:0]  sel_in,
  output logic      [15:0] period_out,
  output logic      [15:0] high_out
);
  logic        last_reg;
  logic [15:0] run_reg;
  logic [15:0] hi_reg;
  // Sampled on the master clock only, so glitches inside a cycle go unseen.
  always_ff @(posedge mclk_in) begin
    last_reg <= wave_in[sel_in];
    if (wave_in[sel_in] && !last_reg) begin
      period_out <= run_reg + 16'h0001;
      high_out   <= hi_reg;
      run_reg    <= 16'h0000;
      hi_reg     <= 16'h0001;
    end else begin
      run_reg <= run_reg + 16'h0001;
      hi_reg  <= hi_reg + {15'h0000, wave_in[sel_in]};
    end
  end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking testbench of the four channel PWM block.
`timescale 1ns/1ns
`default_nettype none
`include "fcp_params.svh"
module tb;
  logic        mclk_in;
  logic        sys_rst_in;
  logic        clk_en;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [11:0] wb_adr;
  logic [31:0] wb_dat;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  logic [3:0]  wave;
  logic        irq;
  logic [1:0]  mon_sel;
  logic [15:0] mon_per;
  logic [15:0] mon_hi;
  int          n_fail;
  int          comparisons;

  fcp_pwm dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .periph_clk_en_in(clk_en), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
    .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(4'hF),
    .wb_dat_in(wb_dat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .channel_wave_out(wave), .irq_out(irq));
  fcp_pin_monitor mon_u (.mclk_in(mclk_in), .wave_in(wave),
    .sel_in(mon_sel), .period_out(mon_per), .high_out(mon_hi));

  always #5 mclk_in = ~mclk_in;

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  // Ack is sampled at the rising edge; the request stands one edge past it
  // and is released by non-blocking assignment right after that next edge.
  task automatic xfer(input logic we, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge mclk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge mclk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    if (n >= 50) check(32'h0000_0000, 32'h0000_0001, "no ack");
    q = wb_dat_out;
    @(posedge mclk_in);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input string what);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    check(q, exp, what);
  endtask

  function automatic logic [11:0] ch(input int i, input logic [4:0] off);
    return 12'h200 + 12'(i * 32) + {7'h00, off};
  endfunction

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  task automatic measure(input logic [1:0] s, input logic [15:0] per,
                         input logic [15:0] hi);
    mon_sel <= s;
    wait_cyc(40);
    check({16'h0000, mon_per}, {16'h0000, per}, "period");
    check({16'h0000, mon_hi}, {16'h0000, hi}, "high time");
  endtask

  task automatic t_reset();
    rd_chk(`FCP_OFF_MODE, 32'h0000_0000, "mode");
    rd_chk(`FCP_OFF_STAT, 32'h0000_0000, "status");
    rd_chk(12'h100, 32'h0000_0000, "unmapped");
    check({27'h0, wave, irq}, 32'h0000_0000, "idle pins");
    $display("test reset done");
  endtask

  task automatic t_left();
    wr(ch(0, `FCP_CH_CMR), 32'h0000_0000);
    wr(ch(0, `FCP_CH_PERIOD), 32'h0000_0004);
    wr(ch(0, `FCP_CH_DUTY), 32'h0000_0001);
    wr(`FCP_OFF_IER, 32'h0000_0001);
    wr(`FCP_OFF_ENA, 32'h0000_0001);
    measure(2'd0, 16'h0004, 16'h0003);
    check({31'h0, irq}, 32'h0000_0001, "irq");
    rd_chk(`FCP_OFF_ISR, 32'h0000_0001, "isr");
    wr(ch(0, `FCP_CH_DUTY), 32'h0000_0003);
    wr(ch(0, `FCP_CH_UPDATE), 32'h0000_0002);
    measure(2'd0, 16'h0004, 16'h0002);
    wr(`FCP_OFF_IDR, 32'h0000_0001);
    wait_cyc(3);
    check({31'h0, irq}, 32'h0000_0000, "irq masked");
    $display("test left done");
  endtask

  task automatic t_div();
    wr(`FCP_OFF_MODE, 32'h0000_0103);
    wr(ch(1, `FCP_CH_CMR), 32'h0000_000B);
    wr(ch(1, `FCP_CH_PERIOD), 32'h0000_0002);
    wr(ch(1, `FCP_CH_DUTY), 32'h0000_0001);
    wr(`FCP_OFF_ENA, 32'h0000_0002);
    measure(2'd1, 16'h000C, 16'h0006);
    rd_chk(`FCP_OFF_STAT, 32'h0000_0003, "status");
    $display("test divider done");
  endtask

  task automatic t_center();
    wr(ch(2, `FCP_CH_CMR), 32'h0000_0100);
    wr(ch(2, `FCP_CH_PERIOD), 32'h0000_0003);
    wr(ch(2, `FCP_CH_DUTY), 32'h0000_0001);
    wr(`FCP_OFF_ENA, 32'h0000_0004);
    measure(2'd2, 16'h0006, 16'h0005);
    $display("test center done");
  endtask

  task automatic t_gate();
    logic [31:0] q1;
    logic [31:0] q2;
    clk_en <= 1'b0;
    wait_cyc(2);
    xfer(1'b0, ch(0, `FCP_CH_COUNT), 32'h0000_0000, q1);
    wr(`FCP_OFF_MODE, 32'h0205_0103);
    rd_chk(`FCP_OFF_MODE, 32'h0205_0103, "mode clock off");
    xfer(1'b0, ch(0, `FCP_CH_COUNT), 32'h0000_0000, q2);
    check(q2, q1, "frozen count");
    clk_en <= 1'b1;
    measure(2'd0, 16'h0004, 16'h0002);
    $display("test gating done");
  endtask

  task automatic t_misc();
    wr(`FCP_OFF_DIS, 32'h0000_0002);
    rd_chk(`FCP_OFF_STAT, 32'h0000_0005, "status");
    wr(`FCP_OFF_MODE, 32'h0000_0103);
    wr(ch(3, `FCP_CH_CMR), 32'h0000_020C);
    wait_cyc(2);
    check({31'h0, wave[3]}, 32'h0000_0001, "polarity");
    wr(ch(3, `FCP_CH_PERIOD), 32'h0000_0004);
    wr(ch(3, `FCP_CH_DUTY), 32'h0000_0002);
    wr(`FCP_OFF_ENA, 32'h0000_000A);
    rd_chk(`FCP_OFF_STAT, 32'h0000_000F, "sync start");
    wait_cyc(20);
    rd_chk(ch(3, `FCP_CH_COUNT), 32'h0000_0000, "zero divisor");
    $display("test misc done");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk_in);
    n_fail++;
    close_out();
  end

  initial begin
    mclk_in = 1'b0;
    sys_rst_in = 1'b1;
    clk_en = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 12'h000;
    wb_dat = 32'h0000_0000;
    mon_sel = 2'd0;
    n_fail = 0;
    comparisons = 0;
    wait_cyc(10);
    sys_rst_in <= 1'b0;
    t_reset();
    t_left();
    t_div();
    t_center();
    t_gate();
    t_misc();
    close_out();
  end
endmodule
`default_nettype wire
